//--- design/iord_decode.sv
// Purpose: i/o register space decode and register bank
// Assumes: core issues one request per cycle; answer one cycle later
// Notes: port ops use i/o address, memory ops use data-space address
// Functional notes
// RL1: software writes zero to reserved bit positions when writing a register.
// RL2: the master never writes an address marked reserved.
// RL3: registers at i/o 0x00..0x1F accept single-bit set and clear operations.
// RL4: bit test on the bit-accessible range returns the selected bit's value.
// RL5: certain status flags clear when a one is written and keep on a zero.
// RL6: a single-bit operation changes only the addressed bit.
// RL7: bit operations above i/o 0x1F are ignored.
// RL8: port reads and writes use i/o addresses 0x00..0x3F.
// RL9: memory access reaches an i/o register at its i/o address plus 0x20.
// RL10: extended region 0x60..0xFF is reachable only by memory access.
// RL11: reserved addresses and bits read zero and ignore writes.
`timescale 1ns/1ps
`include "iord_cfg.svh"
module iord_decode (
	input wire logic mclk,
	input wire logic arst_n,
	input wire iord_pkg::iord_req_t req,
	input wire logic [7:0] flag_set,
	output iord_pkg::iord_rsp_t rsp_q,
	output logic [7:0] bit_reg_q,
	output logic [7:0] ctl_reg_q
);
	logic [7:0] daddr;
	logic valid;
	logic is_wr;
	logic is_bit;
	logic [7:0] regs_q [0:255];
	logic [7:0] rmask [0:255];
	logic [7:0] w1c_mask;
	logic [7:0] rd_val;

	// port ops carry i/o address; shift into data space
	always_comb begin
		daddr = req.addr;
		valid = 1'b0;
		is_wr = 1'b0;
		is_bit = 1'b0;
		unique case (req.op)
			iord_pkg::IORD_OP_PORT_RD, iord_pkg::IORD_OP_PORT_WR: begin
				daddr = req.addr + `IORD_DS_OFFSET; // RL9
				valid = req.addr <= `IORD_PORT_MAX; // RL8 RL10
				is_wr = req.op == iord_pkg::IORD_OP_PORT_WR;
			end
			iord_pkg::IORD_OP_MEM_RD, iord_pkg::IORD_OP_MEM_WR: begin
				valid = req.addr >= `IORD_DS_OFFSET; // RL9
				is_wr = req.op == iord_pkg::IORD_OP_MEM_WR;
			end
			iord_pkg::IORD_OP_BIT_SET, iord_pkg::IORD_OP_BIT_CLR, iord_pkg::IORD_OP_BIT_TEST: begin
				daddr = req.addr + `IORD_DS_OFFSET;
				valid = req.addr <= `IORD_BIT_MAX; // RL3 RL7
				is_bit = 1'b1;
			end
			iord_pkg::IORD_OP_NONE: begin
				valid = 1'b0;
			end
		endcase
	end

	// implemented-bit masks; everything else is reserved
	always_comb begin
		for (int i = 0; i < 256; i++) begin
			rmask[i] = 8'h00;
		end
		// one bit-accessible store so low-range bit ops have a target
		rmask[`IORD_A_GPS0] = 8'hFF; // RL3
		rmask[`IORD_A_EEAR_HI] = 8'h01;
		rmask[`IORD_A_TMR_GEN] = 8'h83;
		rmask[`IORD_A_T0_CTLA] = 8'hC3;
		rmask[`IORD_A_T0_CTLB] = 8'h87;
		rmask[`IORD_A_T0_CNT] = 8'hFF;
		rmask[`IORD_A_T0_CMPA] = 8'hFF;
		rmask[`IORD_A_GPS1] = 8'hFF;
		rmask[`IORD_A_GPS2] = 8'hFF;
		rmask[`IORD_A_SPI_CTL] = 8'hFF;
		rmask[`IORD_A_SPI_STS] = 8'hC1;
		rmask[`IORD_A_SPI_DAT] = 8'hFF;
		rmask[`IORD_A_CMP_CS] = 8'hFF;
		rmask[`IORD_A_DBG_DAT] = 8'hFF;
		rmask[`IORD_A_SLP_CTL] = 8'h07;
		rmask[`IORD_A_RST_CAUSE] = 8'h0F;
		rmask[`IORD_A_CORE_CTL] = 8'h70;
		rmask[`IORD_A_SELFPGM] = 8'h7F;
		rmask[`IORD_A_SP_LO] = 8'hFF;
		rmask[`IORD_A_SP_HI] = 8'hFF;
		rmask[`IORD_A_STATUS] = 8'hFF;
		rmask[`IORD_A_WDOG] = 8'hFF;
		rmask[`IORD_A_CLK_PRE] = 8'h8F;
		rmask[`IORD_A_CLK_SW] = 8'h9F;
		rmask[`IORD_A_CLK_SEL] = 8'h7F;
		rmask[`IORD_A_PWR_RED] = 8'h3F;
		rmask[`IORD_A_OSC_TRIM] = 8'hFF;
		rmask[`IORD_A_PCI_CTL] = 8'h03;
		rmask[`IORD_A_EXT_SENSE] = 8'h0F;
		rmask[`IORD_A_PC_MASK0] = 8'hFF;
		rmask[`IORD_A_PC_MASK1] = 8'hFF;
		rmask[`IORD_A_T0_IMASK] = 8'h03;
		rmask[`IORD_A_T1_IMASK] = 8'h27;
	end

	// write-one-to-clear flags; only the reset-cause flags are stored here
	always_comb begin
		w1c_mask = (daddr == `IORD_A_RST_CAUSE) ? 8'h0F : 8'h00;
	end

	assign rd_val = regs_q[daddr] & rmask[daddr]; // RL11

	// register bank; hardware flag set wins over a clearing write
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < 256; i++) begin
				regs_q[i] <= `IORD_RESET_VAL;
			end
		end else begin
			if (valid && is_wr) begin
				regs_q[daddr] <= ((req.wdata & ~w1c_mask) | (regs_q[daddr] & w1c_mask & ~req.wdata))
					& rmask[daddr]; // RL5 RL11
			end else if (valid && is_bit && req.op == iord_pkg::IORD_OP_BIT_SET) begin
				regs_q[daddr][req.bit_sel] <= rmask[daddr][req.bit_sel]; // RL3 RL6
			end else if (valid && is_bit && req.op == iord_pkg::IORD_OP_BIT_CLR) begin
				regs_q[daddr][req.bit_sel] <= 1'b0; // RL3 RL6
			end
			regs_q[`IORD_A_RST_CAUSE] <= (regs_q[`IORD_A_RST_CAUSE]
				& ~((valid && is_wr && daddr == `IORD_A_RST_CAUSE) ? req.wdata : 8'h00))
				| (flag_set & 8'h0F); // RL5
		end
	end

	// answer registered one cycle after the request
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rsp_q <= '0;
		end else begin
			rsp_q.hit <= valid;
			rsp_q.rdata <= (valid && !is_wr && !is_bit) ? rd_val : 8'h00; // RL11
			rsp_q.bit_val <= valid && req.op == iord_pkg::IORD_OP_BIT_TEST && rd_val[req.bit_sel]; // RL4
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			bit_reg_q <= 8'h00;
			ctl_reg_q <= 8'h00;
		end else begin
			bit_reg_q <= regs_q[`IORD_A_RST_CAUSE];
			ctl_reg_q <= regs_q[`IORD_A_CORE_CTL];
		end
	end

	chk_bitop_range: assert property (@(posedge mclk) disable iff (!arst_n) // RL7
		(req.op == iord_pkg::IORD_OP_BIT_SET && req.addr > `IORD_BIT_MAX) |=> !rsp_q.hit)
		else $error("bit op above range answered");
	chk_port_range: assert property (@(posedge mclk) disable iff (!arst_n) // RL10
		(req.op == iord_pkg::IORD_OP_PORT_RD && req.addr > `IORD_PORT_MAX) |=> rsp_q.rdata == 8'h00)
		else $error("port op reached extended space");
	chk_w1c_flag: assert property (@(posedge mclk) disable iff (!arst_n) // RL5
		(valid && is_wr && daddr == `IORD_A_RST_CAUSE && flag_set == 8'h00)
		|=> (regs_q[`IORD_A_RST_CAUSE] & $past(req.wdata)) == 8'h00)
		else $error("flag not cleared by one");
	chk_bit_set: assert property (@(posedge mclk) disable iff (!arst_n) // RL3
		(req.op == iord_pkg::IORD_OP_BIT_SET && req.addr <= `IORD_BIT_MAX && flag_set == 8'h00)
		|=> regs_q[$past(daddr)] == ($past(rd_val) | ($past(rmask[daddr]) & (8'h01 << $past(req.bit_sel)))))
		else $error("bit set touched other bits");
	chk_bit_clear: assert property (@(posedge mclk) disable iff (!arst_n) // RL6
		(req.op == iord_pkg::IORD_OP_BIT_CLR && req.addr <= `IORD_BIT_MAX && flag_set == 8'h00)
		|=> regs_q[$past(daddr)] == ($past(rd_val) & ~(8'h01 << $past(req.bit_sel))))
		else $error("bit clear touched other bits");
	chk_set_wins: assert property (@(posedge mclk) disable iff (!arst_n) // RL5
		(valid && is_wr && daddr == `IORD_A_RST_CAUSE && (flag_set & 8'h0F) != 8'h00)
		|=> (regs_q[`IORD_A_RST_CAUSE] & $past(flag_set) & 8'h0F) == ($past(flag_set) & 8'h0F))
		else $error("clearing write beat a flag set");
	chk_port_offset: assert property (@(posedge mclk) disable iff (!arst_n) // RL9
		(req.op == iord_pkg::IORD_OP_PORT_RD && req.addr <= `IORD_PORT_MAX)
		|=> rsp_q.rdata == ($past(regs_q[req.addr + 8'h20]) & $past(rmask[req.addr + 8'h20])))
		else $error("port read not at shifted address");
	chk_reserved_read: assert property (@(posedge mclk) disable iff (!arst_n) // RL11
		(valid && !is_wr && !is_bit) |=> (rsp_q.rdata & ~$past(rmask[daddr])) == 8'h00)
		else $error("reserved bit read nonzero");
	cov_port_wr: cover property (@(posedge mclk) disable iff (!arst_n) req.op == iord_pkg::IORD_OP_PORT_WR);
	cov_bit_test: cover property (@(posedge mclk) disable iff (!arst_n) rsp_q.bit_val);
	cov_mem_rd: cover property (@(posedge mclk) disable iff (!arst_n) req.op == iord_pkg::IORD_OP_MEM_RD && valid);
endmodule : iord_decode

//--- design/iord_cfg.svh
// Purpose: constants for the i/o register space decoder
// Assumes: 8-bit data, 8-bit data-space address
// Notes: offsets are data-space addresses
`ifndef IORD_CFG_SVH
`define IORD_CFG_SVH
`define IORD_DS_OFFSET 8'h20
`define IORD_PORT_MAX 8'h3F
`define IORD_BIT_MAX 8'h1F
`define IORD_EXT_LO 8'h60
`define IORD_A_GPS0 8'h3E
`define IORD_A_EEAR_HI 8'h42
`define IORD_A_TMR_GEN 8'h43
`define IORD_A_T0_CTLA 8'h45
`define IORD_A_T0_CTLB 8'h46
`define IORD_A_T0_CNT 8'h47
`define IORD_A_T0_CMPA 8'h48
`define IORD_A_GPS1 8'h4A
`define IORD_A_GPS2 8'h4B
`define IORD_A_SPI_CTL 8'h4C
`define IORD_A_SPI_STS 8'h4D
`define IORD_A_SPI_DAT 8'h4E
`define IORD_A_CMP_CS 8'h50
`define IORD_A_DBG_DAT 8'h51
`define IORD_A_SLP_CTL 8'h53
`define IORD_A_RST_CAUSE 8'h54
`define IORD_A_CORE_CTL 8'h55
`define IORD_A_SELFPGM 8'h57
`define IORD_A_SP_LO 8'h5D
`define IORD_A_SP_HI 8'h5E
`define IORD_A_STATUS 8'h5F
`define IORD_A_WDOG 8'h60
`define IORD_A_CLK_PRE 8'h61
`define IORD_A_CLK_SW 8'h62
`define IORD_A_CLK_SEL 8'h63
`define IORD_A_PWR_RED 8'h64
`define IORD_A_OSC_TRIM 8'h66
`define IORD_A_PCI_CTL 8'h68
`define IORD_A_EXT_SENSE 8'h69
`define IORD_A_PC_MASK0 8'h6B
`define IORD_A_PC_MASK1 8'h6C
`define IORD_A_T0_IMASK 8'h6E
`define IORD_A_T1_IMASK 8'h6F
`define IORD_RESET_VAL 8'h00
`endif

//--- design/iord_pkg.sv
// Purpose: types for the i/o register space decoder
// Assumes: single core master
// Notes: constants live in iord_cfg.svh
package iord_pkg;
	typedef enum logic [2:0] {
		IORD_OP_NONE,
		IORD_OP_PORT_RD,
		IORD_OP_PORT_WR,
		IORD_OP_MEM_RD,
		IORD_OP_MEM_WR,
		IORD_OP_BIT_SET,
		IORD_OP_BIT_CLR,
		IORD_OP_BIT_TEST
	} iord_op_t;
	typedef struct packed {
		iord_op_t op;
		logic [7:0] addr;
		logic [2:0] bit_sel;
		logic [7:0] wdata;
	} iord_req_t;
	typedef struct packed {
		logic [7:0] rdata;
		logic bit_val;
		logic hit;
	} iord_rsp_t;
endpackage : iord_pkg

//--- verification/iord_core.sv
// Purpose: core-side request source for the decoder
// Assumes: one request per call, idle cycle between
// Notes: request held for exactly one sampling edge
`timescale 1ns/1ps
module iord_core (
	input wire logic mclk,
	output iord_pkg::iord_req_t req
);
	initial req = '0;
	task automatic issue(input iord_pkg::iord_op_t op, input logic [7:0] a, input logic [2:0] b,
		input logic [7:0] w);
		@(posedge mclk);
		req <= '{op, a, b, w};
		@(posedge mclk);
		req <= '0;
	endtask : issue
endmodule : iord_core

//--- verification/io_register_space_decode_bench.sv
// Purpose: self-checking bench for the i/o register decoder
// Assumes: one clock, async active-low reset
// Notes: op index follows the package enum order
`timescale 1ns/1ps
module io_register_space_decode_bench;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] flag_set = 8'h00;
	iord_pkg::iord_req_t req;
	iord_pkg::iord_rsp_t rsp_q;
	logic [7:0] bit_reg_q;
	logic [7:0] ctl_reg_q;
	logic [7:0] m [256] = '{default: 8'h00};
	logic [7:0] v;
	int fails = 0;
	int cmp_count = 0;
	int unsigned seed = 29;
	always #25 mclk = ~mclk;
	iord_core iord_core_i (.mclk(mclk), .req(req));
	iord_decode iord_decode_i (.mclk(mclk), .arst_n(arst_n), .req(req), .flag_set(flag_set),
		.rsp_q(rsp_q), .bit_reg_q(bit_reg_q), .ctl_reg_q(ctl_reg_q));
	function logic [7:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : xs
	function logic [7:0] msk(input logic [7:0] a);
		case (a)
			8'h54: return 8'h0F;
			8'h55: return 8'h70;
			8'h3E, 8'h4A, 8'h5F, 8'h6C: return 8'hFF;
			default: return 8'h00;
		endcase
	endfunction : msk
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask : chk
	// k: 1 port rd, 2 port wr, 3 mem rd, 4 mem wr, 5 set, 6 clear, 7 test
	task automatic acc(input int k, input logic [7:0] a, input logic [2:0] b, input logic [7:0] w);
		logic [7:0] da;
		logic h;
		logic rd;
		logic [7:0] mk;
		da = (k == 3 || k == 4) ? a : a + 8'h20;
		mk = msk(da);
		h = (k == 3 || k == 4) ? (a >= 8'h20) : (k < 3) ? (a <= 8'h3F) : (a <= 8'h1F);
		rd = (k == 1 || k == 3);
		iord_core_i.issue(iord_pkg::iord_op_t'(k), a, b, w);
		#1;
		chk("hit", {7'h00, h}, {7'h00, rsp_q.hit});
		if (rd || !h) chk("rdata", h ? m[da] : 8'h00, rsp_q.rdata);
		if (k == 7) chk("bit_val", {7'h00, h & m[da][b]}, {7'h00, rsp_q.bit_val});
		// bit ops touch only the addressed bit; reserved bits stay zero
		if (h && (k == 5 || k == 6)) m[da][b] = (k == 5) && mk[b];
		if (h && (k == 2 || k == 4)) m[da] = (da == 8'h54) ? (m[da] & ~w) : (w & mk);
	endtask : acc
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : conclude
	initial begin
		#100000;
		fails++;
		conclude();
	end
	initial begin
		repeat (4) @(posedge mclk);
		arst_n <= 1'b1;
		acc(1, 8'h35, 3'h0, 8'h00);
		for (int i = 0; i < 4; i++) begin
			v = xs();
			acc(2, 8'h35, 3'h0, v & 8'h70);
			acc(3, 8'h55, 3'h0, 8'h00);
			chk("ctl_reg", m[8'h55], ctl_reg_q);
			acc(4, 8'h6C, 3'h0, v);
			acc(3, 8'h6C, 3'h0, 8'h00);
			acc(1, 8'h6C, 3'h0, 8'h00);
		end
		@(posedge mclk) flag_set <= 8'h0F;
		@(posedge mclk) flag_set <= 8'h00;
		m[8'h54] = 8'h0F;
		acc(4, 8'h54, 3'h0, 8'h05);
		acc(1, 8'h34, 3'h0, 8'h00);
		chk("flags", 8'h0A, bit_reg_q);
		acc(2, 8'h34, 3'h0, 8'h00);
		acc(3, 8'h54, 3'h0, 8'h00);
		for (int i = 0; i < 8; i++) begin
			acc(5 + i % 2, 8'h1E, i[2:0], 8'h00);
			acc(7, 8'h1E, i[2:0], 8'h00);
			acc(5 + i % 2, 8'h35, i[2:0], 8'h00);
			acc(7, 8'h20, i[2:0], 8'h00);
		end
		chk("ctl_reg", m[8'h55], ctl_reg_q);
		acc(1, 8'h36, 3'h0, 8'h00);
		acc(3, 8'h56, 3'h0, 8'h00);
		acc(3, 8'h1F, 3'h0, 8'h00);
		acc(3, 8'h3E, 3'h0, 8'h00);
		conclude();
	end
endmodule : io_register_space_decode_bench
